// ---- pg_delay_loop_capture_config.sv ----
// pg_delay_loop_capture_config: output-valid delay timer, adaptive loop
// tuning, inductance value and fault capture mask, reached by command code.
// assumes the command port and comparator/fault inputs are on clk_i; the
// enable pin is asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
module pg_delay_loop_capture_config #(
  parameter int unsigned CYCLES_PER_MS  = pg_cfg_pkg::CYC_PER_MS,
  parameter int unsigned MIN_ENABLE_CYC = pg_cfg_pkg::MIN_ENABLE_CYC
) (
  input  wire  logic                     clk_i,
  input  wire  logic                     rst_i,
  input  wire  pg_cfg_pkg::reg_req_t     req_i,
  output logic [15:0]                    reg_rdata_o,
  output logic                           reg_ack_o,
  output logic                           reg_err_o,
  input  wire  logic                     enable_pin_i,
  input  wire  logic                     vout_above_thr_i,
  output logic                           output_valid_pin_o,
  output logic [1:0]                     gain_div_sel_o,
  output logic [11:0]                    ss_threshold_o,
  output pg_cfg_pkg::linear11_t          inductance_o,
  input  wire  pg_cfg_pkg::fault_vec_t   fault_events_i,
  output logic                           capture_trigger_o,
  output pg_cfg_pkg::fault_vec_t         capture_cause_o
);
  import pg_cfg_pkg::*;

  // register file
  linear11_t    delay_q,       delay_d;
  logic [31:0]  delay_cyc_q,   delay_cyc_d;
  loop_tuning_t tuning_q,      tuning_d;
  linear11_t    induct_q,      induct_d;
  fault_vec_t   mask_q,        mask_d;
  logic [15:0]  rdata_q,       rdata_d;
  logic         ack_q,         ack_d;
  logic         err_q,         err_d;

  logic         wr_valid;
  logic [31:0]  wr_cycles;

  linear_delay_check #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) i_linear_delay_check (
    .value_i  (linear11_t'(req_i.wdata)),
    .valid_o  (wr_valid),
    .cycles_o (wr_cycles)
  );

  always_comb begin
    delay_d     = delay_q;
    delay_cyc_d = delay_cyc_q;
    tuning_d    = tuning_q;
    induct_d    = induct_q;
    mask_d      = mask_q;
    rdata_d     = rdata_q;
    ack_d       = req_i.wr | req_i.rd;
    err_d       = 1'b0;
    if (req_i.wr) begin
      case (req_i.addr)
        ADDR_OUTPUT_VALID_DELAY: begin
          if (wr_valid) begin
            delay_d     = linear11_t'(req_i.wdata);
            delay_cyc_d = wr_cycles;
          end else begin
            err_d = 1'b1;
          end
        end
        ADDR_LOOP_GAIN_TUNING: begin
          tuning_d        = loop_tuning_t'(req_i.wdata);
          tuning_d.unused = 2'h0;
        end
        ADDR_INDUCTANCE_VALUE:   induct_d = linear11_t'(req_i.wdata);
        ADDR_CAPTURE_FAULT_MASK: mask_d = fault_vec_t'(req_i.wdata);
        default:                 err_d = 1'b1;
      endcase
    end else if (req_i.rd) begin
      case (req_i.addr)
        ADDR_OUTPUT_VALID_DELAY: rdata_d = delay_q;
        ADDR_LOOP_GAIN_TUNING:   rdata_d = tuning_q;
        ADDR_INDUCTANCE_VALUE:   rdata_d = induct_q;
        ADDR_CAPTURE_FAULT_MASK: rdata_d = mask_q;
        default: begin
          rdata_d = 16'h0000;
          err_d   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_q     <= linear11_t'(RST_OUTPUT_VALID_DELAY);
      delay_cyc_q <= 32'(CYCLES_PER_MS);
      tuning_q    <= loop_tuning_t'(RST_LOOP_GAIN_TUNING);
      induct_q    <= linear11_t'(RST_INDUCTANCE_VALUE);
      mask_q      <= fault_vec_t'(RST_CAPTURE_FAULT_MASK);
      rdata_q     <= 16'h0000;
      ack_q       <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      delay_q     <= delay_d;
      delay_cyc_q <= delay_cyc_d;
      tuning_q    <= tuning_d;
      induct_q    <= induct_d;
      mask_q      <= mask_d;
      rdata_q     <= rdata_d;
      ack_q       <= ack_d;
      err_q       <= err_d;
    end
  end

  // enable pin synchroniser
  logic en_meta_q;
  logic en_sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
    end else begin
      en_meta_q <= enable_pin_i;
      en_sync_q <= en_meta_q;
    end
  end

  // output-valid timer
  pg_state_t   state_q,   state_d;
  logic [31:0] dly_cnt_q, dly_cnt_d;
  logic [31:0] en_cnt_q,  en_cnt_d;
  logic        pg_q,      pg_d;
  logic        en_long;

  always_comb begin
    state_d   = state_q;
    dly_cnt_d = dly_cnt_q;
    // saturating enabled-time count; cleared the moment the synchronised enable drops
    en_cnt_d  = en_cnt_q;
    if (!en_sync_q) begin
      en_cnt_d = 32'h0000_0000;
    end else if (en_cnt_q < 32'(MIN_ENABLE_CYC)) begin
      en_cnt_d = en_cnt_q + 32'h0000_0001;
    end
    en_long = (en_cnt_d >= 32'(MIN_ENABLE_CYC));
    case (state_q)
      PGS_OFF: begin
        dly_cnt_d = 32'h0000_0000;
        if (en_sync_q && vout_above_thr_i) begin
          state_d = PGS_DELAY;
        end
      end
      PGS_DELAY: begin
        if (!en_sync_q || !vout_above_thr_i) begin
          state_d   = PGS_OFF;
          dly_cnt_d = 32'h0000_0000;
        end else if (dly_cnt_q >= delay_cyc_q) begin
          state_d = PGS_GOOD;
        end else begin
          dly_cnt_d = dly_cnt_q + 32'h0000_0001;
        end
      end
      PGS_GOOD: begin
        if (!en_sync_q || !vout_above_thr_i) begin
          state_d   = PGS_OFF;
          dly_cnt_d = 32'h0000_0000;
        end
      end
      default: begin
        state_d   = PGS_OFF;
        dly_cnt_d = 32'h0000_0000;
      end
    endcase
    pg_d = (state_d == PGS_GOOD) && en_long;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= PGS_OFF;
      dly_cnt_q <= 32'h0000_0000;
      en_cnt_q  <= 32'h0000_0000;
      pg_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      dly_cnt_q <= dly_cnt_d;
      en_cnt_q  <= en_cnt_d;
      pg_q      <= pg_d;
    end
  end

  // fault capture gating
  fault_vec_t cause_q, cause_d;
  logic       trig_q,  trig_d;

  always_comb begin
    // bit order of the events follows the mask layout exactly
    cause_d = fault_events_i & ~mask_q;
    trig_d  = |cause_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_q <= fault_vec_t'(16'h0000);
      trig_q  <= 1'b0;
    end else begin
      cause_q <= cause_d;
      trig_q  <= trig_d;
    end
  end

  assign reg_rdata_o        = rdata_q;
  assign reg_ack_o          = ack_q;
  assign reg_err_o          = err_q;
  assign output_valid_pin_o = pg_q;
  assign gain_div_sel_o     = tuning_q.gain_sel;
  assign ss_threshold_o     = tuning_q.threshold;
  assign inductance_o       = induct_q;
  assign capture_trigger_o  = trig_q;
  assign capture_cause_o    = cause_q;

endmodule : pg_delay_loop_capture_config
`default_nettype wire

// ---- pg_cfg_pkg.sv ----
// pg_cfg_pkg: command codes, reset values, timing constants and carrier types
// for the output-valid delay and loop/capture configuration block.
// assumes a single 50 MHz device clock.
`default_nettype none
package pg_cfg_pkg;

  // command codes of the four settings
  localparam logic [7:0]  ADDR_OUTPUT_VALID_DELAY = 8'hD4;
  localparam logic [7:0]  ADDR_LOOP_GAIN_TUNING   = 8'hD5;
  localparam logic [7:0]  ADDR_INDUCTANCE_VALUE   = 8'hD6;
  localparam logic [7:0]  ADDR_CAPTURE_FAULT_MASK = 8'hD7;

  // reset values
  localparam logic [15:0] RST_OUTPUT_VALID_DELAY  = 16'hBA00;
  localparam logic [15:0] RST_LOOP_GAIN_TUNING    = 16'h2064;
  localparam logic [15:0] RST_INDUCTANCE_VALUE    = 16'hAA66;
  localparam logic [15:0] RST_CAPTURE_FAULT_MASK  = 16'h0000;

  // timing
  localparam int unsigned CLK_FREQ_HZ      = 50_000_000;
  localparam int unsigned HZ_PER_KHZ       = 1000;
  localparam int unsigned CYC_PER_MS       = CLK_FREQ_HZ / HZ_PER_KHZ;
  localparam int unsigned PG_DELAY_MIN_MS  = 0;
  localparam int unsigned PG_DELAY_MAX_MS  = 125;
  localparam int unsigned MIN_ENABLE_MS    = 2;
  localparam int unsigned MIN_ENABLE_CYC   = MIN_ENABLE_MS * CYC_PER_MS;

  // two-byte value: signed exponent above, signed mantissa below
  typedef struct packed {
    logic [4:0]  exponent;
    logic [10:0] mantissa;
  } linear11_t;

  typedef struct packed {
    logic [1:0]  unused;
    logic [1:0]  gain_sel;
    logic [11:0] threshold;
  } loop_tuning_t;

  // capture mask bit layout, 15 down to 0
  typedef struct packed {
    logic rail_phase;
    logic group;
    logic processor;
    logic under_temperature;
    logic over_temperature;
    logic peak_over_current;
    logic peak_under_current;
    logic enable_fault_bus;
    logic input_over_voltage;
    logic output_over_voltage;
    logic output_under_voltage;
    logic power_stage_fault;
    logic sync_loss;
    logic input_under_voltage;
    logic average_over_current;
    logic average_under_current;
  } fault_vec_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    PGS_OFF   = 2'b00,
    PGS_DELAY = 2'b01,
    PGS_GOOD  = 2'b10
  } pg_state_t;

endpackage : pg_cfg_pkg
`default_nettype wire

// ---- linear_delay_check.sv ----
// linear_delay_check: turns a two-byte exponent/mantissa delay in ms into
// clock cycles and tells whether it lies in the permitted range.
// purely combinational; the caller registers what it needs.
`timescale 1ns/1ps
`default_nettype none
module linear_delay_check #(
  parameter int unsigned CYCLES_PER_MS = pg_cfg_pkg::CYC_PER_MS
) (
  input  wire pg_cfg_pkg::linear11_t value_i,
  output logic                       valid_o,
  output logic [31:0]                cycles_o
);
  import pg_cfg_pkg::*;

  logic signed [63:0] prod;
  logic signed [63:0] cyc;
  logic signed [63:0] max_c;
  logic signed [63:0] scaled;
  logic        [4:0]  sh;

  always_comb begin
    // value = mantissa * 2^exponent, both signed
    prod   = 64'($signed(value_i.mantissa));
    cyc    = $signed({32'h0000_0000, 32'(CYCLES_PER_MS)});
    max_c  = $signed({32'h0000_0000, 32'(PG_DELAY_MAX_MS)}) * cyc;
    prod   = prod * cyc;
    sh     = 5'h00;
    scaled = prod;
    valid_o = 1'b0;
    if (!value_i.exponent[4]) begin
      sh      = value_i.exponent;
      scaled  = prod <<< sh;
      valid_o = (prod >= 0) && (scaled <= max_c);
    end else begin
      sh      = 5'(~value_i.exponent + 5'h01);
      scaled  = prod >>> sh;
      // exact compare before truncation, so 125ms plus a fraction fails
      valid_o = (prod >= 0) && (prod <= (max_c <<< sh));
    end
    cycles_o = scaled[31:0];
  end

endmodule : linear_delay_check
`default_nettype wire

// ---- pg_cfg_props.sv ----
// pg_cfg_props: port-level assertions for the config block.
// assumes a bind onto every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module pg_cfg_props #(
  parameter int unsigned MIN_ENABLE_CYC = 20
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire pg_cfg_pkg::reg_req_t   req_i,
  input wire logic                   reg_ack_o,
  input wire logic                   reg_err_o,
  input wire logic                   enable_pin_i,
  input wire logic                   vout_above_thr_i,
  input wire logic                   output_valid_pin_o,
  input wire logic [1:0]             gain_div_sel_o,
  input wire logic [11:0]            ss_threshold_o,
  input wire pg_cfg_pkg::fault_vec_t fault_events_i,
  input wire logic                   capture_trigger_o,
  input wire pg_cfg_pkg::fault_vec_t capture_cause_o
);
  import pg_cfg_pkg::*;
  // raw enable run length; the real count lags behind this one through the synchroniser and stops at MIN_ENABLE_CYC
  int unsigned en_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_pin_i) en_cnt_q <= 0;
    else if (en_cnt_q != 32'hFFFF_FFFF) en_cnt_q <= en_cnt_q + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_after_req_a: assert property ((req_i.wr || req_i.rd) |=> reg_ack_o)
    else $error("missing ack");
  ack_has_cause_a: assert property (reg_ack_o |-> $past(req_i.wr || req_i.rd))
    else $error("stray ack");
  err_with_ack_a: assert property (reg_err_o |-> reg_ack_o)
    else $error("err without ack");
  pin_drop_a: assert property (!vout_above_thr_i |=> !output_valid_pin_o)
    else $error("pin high below threshold");
  pin_rise_a: assert property ($rose(output_valid_pin_o) |->
    $past(vout_above_thr_i) && $past(vout_above_thr_i, 2))
    else $error("pin rose too early");
  pin_enable_a: assert property ($rose(output_valid_pin_o) |-> en_cnt_q >= MIN_ENABLE_CYC)
    else $error("pin rose before enable time");
  cause_subset_a: assert property ((capture_cause_o & ~$past(fault_events_i)) == '0)
    else $error("cause without event");
  trig_cause_a: assert property (capture_trigger_o == (capture_cause_o != '0))
    else $error("trigger and cause disagree");
  gain_write_a: assert property ($changed(gain_div_sel_o) |->
    $past(req_i.wr) || $past(req_i.wr, 2) || $past(rst_i))
    else $error("gain changed without write");
  thr_write_a: assert property ($changed(ss_threshold_o) |->
    $past(req_i.wr) || $past(req_i.wr, 2) || $past(rst_i))
    else $error("threshold changed without write");
  cover property ($rose(output_valid_pin_o));
  cover property (reg_err_o);
  cover property (capture_trigger_o);
endmodule : pg_cfg_props
bind pg_delay_loop_capture_config pg_cfg_props #(.MIN_ENABLE_CYC(MIN_ENABLE_CYC)) i_pg_cfg_props (
  .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
  .enable_pin_i(enable_pin_i), .vout_above_thr_i(vout_above_thr_i),
  .output_valid_pin_o(output_valid_pin_o), .gain_div_sel_o(gain_div_sel_o),
  .ss_threshold_o(ss_threshold_o), .fault_events_i(fault_events_i),
  .capture_trigger_o(capture_trigger_o), .capture_cause_o(capture_cause_o));
`default_nettype wire

// ---- pg_host.sv ----
// pg_host: command-port host model, one-cycle requests on the falling edge.
// assumes the block takes requests on the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module pg_host (
  input  wire logic               clk_i,
  output var pg_cfg_pkg::reg_req_t req_o
);
  import pg_cfg_pkg::*;
  initial req_o = '0;
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d,
                      input logic [1:0] gap);
    repeat (gap) @(negedge clk_i);
    @(negedge clk_i);
    req_o = '{addr: a, wr: w, rd: ~w, wdata: d};
    @(posedge clk_i);
    @(negedge clk_i);
    // released lines must not keep showing the old value
    req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : xfer
endmodule : pg_host
`default_nettype wire

// ---- tb_pg_delay_loop_capture_config.sv ----
// tb_pg_delay_loop_capture_config: self-checking bench for the config block.
// assumes the host model drives the command port; counts are shortened.
`timescale 1ns/1ps
`default_nettype none
module tb_pg_delay_loop_capture_config;
  import pg_cfg_pkg::*;
  localparam int unsigned CPM = 10;
  localparam int unsigned MEC = 20;
  logic        clk_i = 1'b0, rst_i = 1'b1, en = 1'b0, vout = 1'b0, ack, err, pin, trig;
  reg_req_t    req;
  logic [15:0] rdata, d, seed = 16'h2A32;
  logic [1:0]  gsel;
  logic [11:0] thr;
  linear11_t   ind;
  fault_vec_t  ev = '0, cause, m;
  logic [17:0] e, expq[$];
  logic [16:0] dly[4] = '{17'h0_007D, 17'h1_007E, 17'h1_07FF, 17'h1_7840};
  int          n_mismatch = 0, comparisons = 0;
  initial forever #10 clk_i = ~clk_i;
  pg_host i_pg_host (.clk_i(clk_i), .req_o(req));
  pg_delay_loop_capture_config #(.CYCLES_PER_MS(CPM), .MIN_ENABLE_CYC(MEC))
    i_pg_delay_loop_capture_config (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err), .enable_pin_i(en),
    .vout_above_thr_i(vout), .output_valid_pin_o(pin), .gain_div_sel_o(gsel),
    .ss_threshold_o(thr), .inductance_o(ind), .fault_events_i(ev),
    .capture_trigger_o(trig), .capture_cause_o(cause));
  task automatic print_verdict();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  task automatic acc(input logic [7:0] a, input logic w, input logic [15:0] dd,
                     input logic ex, input logic [15:0] x);
    expq.push_back({~w, ex, x});
    i_pg_host.xfer(a, w, dd, 2'(rnd() % 3));
  endtask : acc
  task automatic wait_pin(input int lo, input int hi);
    int n;
    n = 0;
    while (pin !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(16'(n >= lo && n <= hi), 16'h0001);
    if (n >= 300) print_verdict();
  endtask : wait_pin
  // sampled mid-cycle, away from the edge that launches or drops ack
  always @(negedge clk_i) begin
    if (ack === 1'b1) begin
      if (expq.size() == 0) check(16'hDEAD, 16'h0000);
      else begin
        e = expq.pop_front();
        check(16'(err), 16'(e[16]));
        if (e[17]) check(rdata, e[15:0]);
      end
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    check({2'b00, gsel, thr}, 16'h2064);
    check(ind, 16'hAA66);
    acc(8'hD4, 1'b0, 16'h0000, 1'b0, 16'hBA00);
    acc(8'hD5, 1'b0, 16'h0000, 1'b0, 16'h2064);
    acc(8'hD6, 1'b0, 16'h0000, 1'b0, 16'hAA66);
    acc(8'hD7, 1'b0, 16'h0000, 1'b0, 16'h0000);
    acc(8'hD3, 1'b0, 16'h0000, 1'b1, 16'h0000);
    foreach (dly[i]) acc(8'hD4, 1'b1, dly[i][15:0], dly[i][16], 16'h0000);
    acc(8'hD4, 1'b0, 16'h0000, 1'b0, 16'h007D);
    for (int g = 0; g < 4; g++) begin
      d = rnd();
      d[13:12] = 2'(g);
      acc(8'hD5, 1'b1, d, 1'b0, 16'h0000);
      acc(8'hD5, 1'b0, 16'h0000, 1'b0, {2'b00, d[13:0]});
      check({2'b00, gsel, thr}, {2'b00, d[13:0]});
    end
    d = rnd();
    acc(8'hD6, 1'b1, d, 1'b0, 16'h0000);
    acc(8'hD6, 1'b0, 16'h0000, 1'b0, d);
    check(ind, d);
    for (int i = 0; i < 56; i++) begin
      m = (i < 16) ? fault_vec_t'(16'h0001 << i) : rnd();
      acc(8'hD7, 1'b1, m, 1'b0, 16'h0000);
      @(negedge clk_i) ev = (i < 16) ? m : rnd();
      @(posedge clk_i);
      #1;
      check(cause, ev & ~m);
      check(16'(trig), 16'((ev & ~m) != '0));
    end
    acc(8'hD4, 1'b1, 16'h0000, 1'b0, 16'h0000);
    @(negedge clk_i);
    en = 1'b1;
    vout = 1'b1;
    wait_pin(MEC, MEC + 6);
    @(negedge clk_i) vout = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check(16'(pin), 16'h0000);
    acc(8'hD4, 1'b1, 16'h0002, 1'b0, 16'h0000);
    @(negedge clk_i) vout = 1'b1;
    repeat (10) @(negedge clk_i);
    vout = 1'b0;
    @(negedge clk_i) vout = 1'b1;
    wait_pin(2 * CPM, 2 * CPM + 6);
    repeat (4) @(posedge clk_i);
    check(16'(expq.size()), 16'h0000);
    print_verdict();
  end
endmodule : tb_pg_delay_loop_capture_config
`default_nettype wire
